/* File: core/uef_pkg.sv */
//==============================================================================
// Purpose: constants and types shared by the usb event flag block
// Assumes: one 40 MHz core clock, synchronous active-low reset
// Notes: register offsets are word indices; the byte address is four times
package uef_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 18;
  localparam int REG_W = 8;
  localparam int IDX_W = 16;
  localparam int CNT_W = 16;
  localparam logic [IDX_W-1:0] ENABLE_IDX = 16'hFFFD;
  localparam logic [IDX_W-1:0] FLAGS_IDX = 16'hFFFE;
  localparam logic [IDX_W-1:0] VECTOR_IDX = 16'hFFFF;
  localparam logic [1:0] WORD_ALIGNED = 2'h0;
  localparam int BUS_RESET_BIT = 7;
  localparam int SUSPEND_BIT = 6;
  localparam int RESUME_BIT = 5;
  localparam int FRAME_BIT = 4;
  localparam int PSEUDO_FRAME_BIT = 3;
  localparam int SETUP_BIT = 2;
  localparam int RESERVED_BIT = 1;
  localparam int OVERWRITE_BIT = 0;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [REG_W-1:0] ENABLE_WRITABLE = 8'hFD;
  localparam int CLK_KHZ = 40000;
  localparam int FRAME_PERIOD_US = 1000;
  localparam int FRAME_CYCLES = (FRAME_PERIOD_US * CLK_KHZ) / 1000;
  localparam logic [CNT_W-1:0] FRAME_CYCLES_CNT = CNT_W'(FRAME_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  typedef enum logic {UEF_IDLE, UEF_ACTIVE} uef_ctl_phase_t;
  typedef struct packed {
    logic [REG_W-1:0] mask;
    logic [REG_W-1:0] flags;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } uef_top_state_t;
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic pulse;
  } uef_frame_state_t;
  typedef struct packed {
    uef_ctl_phase_t phase;
    logic ovw;
  } uef_setup_state_t;
  function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = regIndex(addr);
    return (addr[1:0] == WORD_ALIGNED) &&
           (idx == ENABLE_IDX || idx == FLAGS_IDX || idx == VECTOR_IDX);
  endfunction
  function automatic logic [DATA_W-1:0] toWord(input logic [REG_W-1:0] v);
    return DATA_W'(v);
  endfunction
endpackage

/* File: core/uef_evt_if.sv */
//==============================================================================
// Purpose: event signals between the flag hub and its helper blocks
// Assumes: all signals on core_clk
// Notes: pulses last one enabled cycle
interface uef_evt_if;
  logic frameLocked;
  logic sofSeen;
  logic pseudoSof;
  logic setupWrite;
  logic setupDone;
  logic xferEnd;
  logic setupOverwrite;
  modport hub (output frameLocked, sofSeen, setupWrite, setupDone, xferEnd,
               input pseudoSof, setupOverwrite);
  modport frame (input frameLocked, sofSeen, output pseudoSof);
  modport setup (input setupWrite, setupDone, xferEnd, output setupOverwrite);
endinterface

/* File: core/uef_pseudo_frame.sv */
//==============================================================================
// Purpose: artificial frame start while the frame timer is unlocked
// Assumes: frame period counted in enabled clock cycles
// Notes: a real frame start restarts the period
module uef_pseudo_frame #(
  parameter logic [uef_pkg::CNT_W-1:0] FRAME_CYCLES = uef_pkg::FRAME_CYCLES_CNT
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  uef_evt_if.frame evt
);
  uef_pkg::uef_frame_state_t state, next_state;
  logic [uef_pkg::CNT_W-1:0] gap;
  always_comb begin
    next_state = state;
    if (clkEn) begin
      next_state.pulse = 1'b0;
      if (evt.frameLocked || evt.sofSeen) begin
        next_state.count = '0;
      end else if (state.count == FRAME_CYCLES - uef_pkg::CNT_ONE) begin
        next_state.count = '0;
        next_state.pulse = 1'b1;
      end else begin
        next_state.count = state.count + uef_pkg::CNT_ONE;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) state <= '0;
    else state <= next_state;
  end
  assign evt.pseudoSof = state.pulse;
  always_ff @(posedge core_clk) begin
    if (!nrst) gap <= '0;
    else if (clkEn) begin
      if (evt.frameLocked || evt.sofSeen) gap <= '0;
      else if (state.pulse) gap <= uef_pkg::CNT_ONE;
      else gap <= gap + uef_pkg::CNT_ONE;
    end
  end
  a_pseudo_period: assert property (
    @(posedge core_clk) disable iff (!nrst) $rose(state.pulse) |-> gap == FRAME_CYCLES)
    else $error("pseudo frame period wrong");
  a_pseudo_unlocked: assert property (
    @(posedge core_clk) disable iff (!nrst) $rose(state.pulse) |-> !$past(evt.frameLocked))
    else $error("pseudo frame while locked");
endmodule

/* File: core/uef_setup_watch.sv */
//==============================================================================
// Purpose: detect setup buffer overwrite inside an open control transfer
// Assumes: transfer end pulse comes from the endpoint engine
// Notes: a new setup after the transfer end is not an overwrite
module uef_setup_watch (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  uef_evt_if.setup evt
);
  uef_pkg::uef_setup_state_t state, next_state;
  always_comb begin
    next_state = state;
    if (clkEn) begin
      next_state.ovw = 1'b0;
      unique case (state.phase)
        uef_pkg::UEF_IDLE: begin
          if (evt.setupDone) next_state.phase = uef_pkg::UEF_ACTIVE;
        end
        uef_pkg::UEF_ACTIVE: begin
          if (evt.setupWrite) next_state.ovw = 1'b1;
          if (evt.xferEnd) next_state.phase = uef_pkg::UEF_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) state <= '0;
    else state <= next_state;
  end
  assign evt.setupOverwrite = state.ovw;
  sequence sOpened;
    clkEn && evt.setupDone && !evt.xferEnd;
  endsequence
  sequence sNewSetup;
    clkEn && evt.setupWrite && !evt.xferEnd;
  endsequence
  a_overwrite_detect: assert property (
    @(posedge core_clk) disable iff (!nrst) sOpened ##1 sNewSetup |=> state.ovw)
    else $error("overwrite not detected");
  a_no_idle_overwrite: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && state.phase == uef_pkg::UEF_IDLE) |=> !state.ovw)
    else $error("overwrite outside transfer");
endmodule

/* File: core/uef_event_flags.sv */
//==============================================================================
// Purpose: usb event flags, interrupt enables and request, apb slave
// Assumes: event inputs are one-cycle pulses synchronous to core_clk
// Notes: clkEn must stay high through an apb access phase
module uef_event_flags #(
  parameter logic [uef_pkg::CNT_W-1:0] FRAME_CYCLES = uef_pkg::FRAME_CYCLES_CNT
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uef_pkg::ADDR_W-1:0] paddr,
  input wire logic [uef_pkg::DATA_W-1:0] pwdata,
  output logic [uef_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busResetDet,
  input wire logic suspendDet,
  input wire logic resumeDet,
  input wire logic sofDet,
  input wire logic frameLocked,
  input wire logic setupDataWr,
  input wire logic setupDone,
  input wire logic ctrlXferEnd,
  output logic usbIrq
);

  //============================================================================
  // helper blocks
  uef_evt_if evtBus();

  assign evtBus.frameLocked = frameLocked;
  assign evtBus.sofSeen = sofDet;
  assign evtBus.setupWrite = setupDataWr;
  assign evtBus.setupDone = setupDone;
  assign evtBus.xferEnd = ctrlXferEnd;

  uef_pseudo_frame #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) pseudoFrame (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .evt(evtBus)
  );

  uef_setup_watch setupWatch (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .evt(evtBus)
  );

  //============================================================================
  // bus decode
  uef_pkg::uef_top_state_t state, next_state;
  logic [uef_pkg::IDX_W-1:0] addrIdx;
  logic setupPhase;
  logic accessDone;
  logic goodWrite;
  logic vecClr;
  logic enableWr;
  logic [uef_pkg::REG_W-1:0] evtVec;
  logic [uef_pkg::REG_W-1:0] flagsUpd;
  logic [uef_pkg::REG_W-1:0] readVal;

  assign addrIdx = uef_pkg::regIndex(paddr);
  assign setupPhase = psel && !penable;
  // pready is registered, so every access has exactly one access cycle
  assign accessDone = psel && penable && state.pready;
  assign goodWrite = accessDone && pwrite && !state.pslverr;
  assign vecClr = goodWrite && (addrIdx == uef_pkg::VECTOR_IDX);
  assign enableWr = goodWrite && (addrIdx == uef_pkg::ENABLE_IDX);

  //============================================================================
  // event collection
  always_comb begin
    evtVec = uef_pkg::REG_RESET;
    evtVec[uef_pkg::BUS_RESET_BIT] = busResetDet;
    evtVec[uef_pkg::SUSPEND_BIT] = suspendDet;
    evtVec[uef_pkg::RESUME_BIT] = resumeDet;
    evtVec[uef_pkg::FRAME_BIT] = sofDet;
    evtVec[uef_pkg::PSEUDO_FRAME_BIT] = evtBus.pseudoSof;
    evtVec[uef_pkg::SETUP_BIT] = setupDone;
    evtVec[uef_pkg::OVERWRITE_BIT] = evtBus.setupOverwrite;
  end

  // the reserved bit has no event, so it can never be set
  generate
    for (genvar i = 0; i < uef_pkg::REG_W; i++) begin : g_flag
      assign flagsUpd[i] = evtVec[i] | (state.flags[i] & ~vecClr);
    end
  endgenerate

  //============================================================================
  // read data
  always_comb begin
    readVal = uef_pkg::REG_RESET;
    if (addrIdx == uef_pkg::ENABLE_IDX) readVal = state.mask;
    if (addrIdx == uef_pkg::FLAGS_IDX) readVal = state.flags;
  end

  //============================================================================
  // next state
  always_comb begin
    next_state = state;
    if (clkEn) begin
      next_state.flags = flagsUpd;
      if (enableWr) begin
        next_state.mask = pwdata[uef_pkg::REG_W-1:0] & uef_pkg::ENABLE_WRITABLE;
      end
      if (setupPhase) begin
        next_state.pready = 1'b1;
        next_state.pslverr = !uef_pkg::isMapped(paddr);
        if (!pwrite && uef_pkg::isMapped(paddr)) begin
          next_state.prdata = uef_pkg::toWord(readVal);
        end else begin
          next_state.prdata = '0;
        end
      end else if (accessDone) begin
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
        next_state.prdata = '0;
      end
      next_state.irq = |(next_state.flags & next_state.mask);
    end
  end

  //============================================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (!nrst) state <= '0;
    else state <= next_state;
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign usbIrq = state.irq;

  //============================================================================
  // checks
  logic anyEvt;
  assign anyEvt = |evtVec;

  sequence sApbSetup;
    clkEn && psel && !penable;
  endsequence

  sequence sApbAccess;
    clkEn && psel && penable && pready;
  endsequence

  a_resume_sets: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && resumeDet) |=> state.flags[uef_pkg::RESUME_BIT])
    else $error("resume flag not set");

  a_flags_readonly: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && goodWrite && addrIdx == uef_pkg::FLAGS_IDX && !anyEvt)
    |=> state.flags == $past(state.flags))
    else $error("flag register changed by write");

  a_vector_clears: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && goodWrite && addrIdx == uef_pkg::VECTOR_IDX && !anyEvt)
    |=> state.flags == uef_pkg::REG_RESET)
    else $error("vector write did not clear flags");

  a_frame_sets: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && sofDet) |=> state.flags[uef_pkg::FRAME_BIT])
    else $error("frame start flag not set");

  a_pseudo_flag: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && evtBus.pseudoSof) |=> state.flags[uef_pkg::PSEUDO_FRAME_BIT])
    else $error("pseudo frame flag not set");

  a_setup_sets: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && setupDone) |=> state.flags[uef_pkg::SETUP_BIT])
    else $error("setup flag not set");

  a_overwrite_flag: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && setupDone && !ctrlXferEnd) ##1 (clkEn && setupDataWr && !ctrlXferEnd)
    |=> ##1 state.flags[uef_pkg::OVERWRITE_BIT])
    else $error("overwrite flag not set");

  a_reserved_zero: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !state.mask[uef_pkg::RESERVED_BIT] && !state.flags[uef_pkg::RESERVED_BIT])
    else $error("reserved bit set");

  a_irq_gating: assert property (
    @(posedge core_clk) disable iff (!nrst)
    usbIrq == |(state.flags & state.mask))
    else $error("interrupt request mismatch");

  a_mask_write: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (sApbAccess and (pwrite && addrIdx == uef_pkg::ENABLE_IDX && !pslverr))
    |=> state.mask == ($past(pwdata[uef_pkg::REG_W-1:0]) & uef_pkg::ENABLE_WRITABLE))
    else $error("mask write lost");

  a_reset_clear: assert property (
    @(posedge core_clk)
    !nrst |=> (state.flags == uef_pkg::REG_RESET && state.mask == uef_pkg::REG_RESET
               && !usbIrq && !pready))
    else $error("reset values wrong");

  a_set_beats_clear: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && vecClr && sofDet) |=> state.flags[uef_pkg::FRAME_BIT])
    else $error("event lost under clear");

  a_apb_one_wait: assert property (
    @(posedge core_clk) disable iff (!nrst)
    sApbSetup |=> pready)
    else $error("no ready after setup");

  a_apb_release: assert property (
    @(posedge core_clk) disable iff (!nrst)
    sApbAccess |=> !pready)
    else $error("ready held after access");

  a_unmapped_error: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (sApbSetup and !uef_pkg::isMapped(paddr)) |=> (pslverr && prdata == '0))
    else $error("unmapped address not refused");

  //============================================================================
  // checks on the bus answers
  sequence sReadSetup;
    clkEn && psel && !penable && !pwrite;
  endsequence

  sequence sVecClear;
    clkEn && vecClr && !anyEvt;
  endsequence

  a_read_mask: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (sReadSetup and (uef_pkg::isMapped(paddr) && addrIdx == uef_pkg::ENABLE_IDX))
    |=> prdata == uef_pkg::toWord($past(state.mask)))
    else $error("mask read wrong");

  a_read_flags: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (sReadSetup and (uef_pkg::isMapped(paddr) && addrIdx == uef_pkg::FLAGS_IDX))
    |=> prdata == uef_pkg::toWord($past(state.flags)))
    else $error("flag read wrong");

  a_vector_read: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (sReadSetup and addrIdx == uef_pkg::VECTOR_IDX) |=> prdata == '0)
    else $error("vector read not zero");

  a_write_no_data: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (sApbSetup and pwrite) |=> prdata == '0)
    else $error("read data on a write");

  a_mapped_ok: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (sApbSetup and uef_pkg::isMapped(paddr)) |=> !pslverr)
    else $error("mapped address refused");

  a_error_ready: assert property (
    @(posedge core_clk) disable iff (!nrst)
    pslverr |-> pready)
    else $error("error without ready");

  a_prdata_idle: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !pready |-> prdata == '0)
    else $error("read data outside access");

  //============================================================================
  // checks on masks, the request and the bus reset and suspend flags
  a_mask_stable: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !(clkEn && enableWr) |=> state.mask == $past(state.mask))
    else $error("mask changed without write");

  a_irq_rises: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && !enableWr && |(evtVec & state.mask)) |=> usbIrq)
    else $error("enabled event gave no request");

  a_irq_masked: assert property (
    @(posedge core_clk) disable iff (!nrst)
    state.mask == uef_pkg::REG_RESET |-> !usbIrq)
    else $error("request with all masks clear");

  a_irq_holds: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (usbIrq && !(clkEn && (vecClr || enableWr))) |=> usbIrq)
    else $error("request dropped early");

  a_irq_clears: assert property (
    @(posedge core_clk) disable iff (!nrst)
    sVecClear |=> !usbIrq)
    else $error("request held after clear");

  a_bus_reset_sets: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && busResetDet) |=> state.flags[uef_pkg::BUS_RESET_BIT])
    else $error("bus reset flag not set");

  a_suspend_sets: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (clkEn && suspendDet) |=> state.flags[uef_pkg::SUSPEND_BIT])
    else $error("suspend flag not set");

  //============================================================================
  // checks on each flag bit
  generate
    for (genvar b = 0; b < uef_pkg::REG_W; b++) begin : g_chk
      a_flag_sticky: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (state.flags[b] && !(clkEn && vecClr)) |=> state.flags[b])
        else $error("flag lost without clear");

      a_flag_cause: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (!state.flags[b] && !(clkEn && evtVec[b])) |=> !state.flags[b])
        else $error("flag set without event");
    end
  endgenerate

endmodule

/* File: testbench/uef_usb_model.sv */
//==============================================================================
// Purpose: usb engine stand-in that drives the event pulses
// Assumes: one core_clk, every pulse one cycle wide
// Notes: the bench calls fire and lock
module uef_usb_model (
  input wire logic core_clk,
  output logic busResetDet,
  output logic suspendDet,
  output logic resumeDet,
  output logic sofDet,
  output logic frameLocked,
  output logic setupDataWr,
  output logic setupDone,
  output logic ctrlXferEnd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ev = 8'h00;
  initial frameLocked = 1'b1;
  assign busResetDet = ev[7];
  assign suspendDet = ev[6];
  assign resumeDet = ev[5];
  assign sofDet = ev[4];
  assign setupDone = ev[2];
  assign setupDataWr = ev[1];
  assign ctrlXferEnd = ev[0];
  task automatic fire(input logic [7:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= 8'h00;
  endtask
  task automatic pair(input logic [7:0] a, input logic [7:0] b);
    @(posedge core_clk);
    ev <= a;
    @(posedge core_clk);
    ev <= b;
    @(posedge core_clk);
    ev <= 8'h00;
  endtask
  task automatic lock(input logic v);
    @(posedge core_clk);
    frameLocked <= v;
  endtask
endmodule

/* File: testbench/uef_event_flags_tb_top.sv */
//==============================================================================
// Purpose: self-checking bench for the usb event flag block
// Assumes: apb master in the bench, usb side in uef_usb_model
// Notes: frame period shortened to 8 cycles
module uef_event_flags_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FC = 8;
  localparam logic [17:0] A_EN = {uef_pkg::ENABLE_IDX, 2'h0};
  localparam logic [17:0] A_FL = {uef_pkg::FLAGS_IDX, 2'h0};
  localparam logic [17:0] A_VEC = {uef_pkg::VECTOR_IDX, 2'h0};
  logic core_clk = 1'b0;
  logic nrst, clkEn, psel, penable, pwrite, pready, pslverr, usbIrq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rng, v;
  logic busResetDet, suspendDet, resumeDet, sofDet, frameLocked;
  logic setupDataWr, setupDone, ctrlXferEnd;
  logic [32:0] expQ[$];
  int errCount = 0;
  int numChecks = 0;
  int cycles = 0;
  int n;
  longint t1;
  uef_event_flags #(.FRAME_CYCLES(16'h0008)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busResetDet(busResetDet), .suspendDet(suspendDet), .resumeDet(resumeDet),
    .sofDet(sofDet), .frameLocked(frameLocked), .setupDataWr(setupDataWr),
    .setupDone(setupDone), .ctrlXferEnd(ctrlXferEnd), .usbIrq(usbIrq));
  uef_usb_model i_usb (
    .core_clk(core_clk), .busResetDet(busResetDet), .suspendDet(suspendDet),
    .resumeDet(resumeDet), .sofDet(sofDet), .frameLocked(frameLocked),
    .setupDataWr(setupDataWr), .setupDone(setupDone), .ctrlXferEnd(ctrlXferEnd));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tallyAndFinish();
    if (errCount == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // =====================================================================
  // apb master, expectation noted at setup
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    expQ.push_back(exp);
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, {25'h0, e});
  endtask
  task automatic chkIrq(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    check("irq", {32'h0, usbIrq}, {32'h0, e});
  endtask
  task automatic waitIrq(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      #1;
      c++;
    end while (usbIrq !== 1'b1 && c < 100);
  endtask
  // =====================================================================
  // monitor: oldest note against each answer
  always @(posedge core_clk) begin
    cycles++;
    if (psel && penable && pready === 1'b1) begin
      check("apb", {pslverr, prdata}, expQ.size() > 0 ? expQ.pop_front() : 33'hX);
    end
    if (cycles > 20000) begin
      errCount++;
      tallyAndFinish();
    end
  end
  initial begin
    rng = 32'h0001_2BED;
    nrst = 1'b0;
    clkEn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rd(A_EN, 8'h00);
    rd(A_FL, 8'h00);
    chkIrq(1'b0);
    repeat (4) begin
      v = rnd();
      wr(A_EN, v);
      rd(A_EN, v[7:0] & 8'hFD);
    end
    apb(1'b0, 18'h3FFF0, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 18'h3FFF5, 32'hFF, {1'b1, 32'h0});
    rd(A_EN, v[7:0] & 8'hFD);
    rd(A_VEC, 8'h00);
    // =====================================================================
    // bus reset, suspend, resume, frame and setup events alone: flag, masked, enabled, cleared
    for (int i = 7; i >= 0; i--) begin
      if (i inside {7, 6, 5, 4, 2}) begin
        wr(A_EN, 32'h0);
        i_usb.fire(8'h01 << i);
        rd(A_FL, 8'h01 << i);
        chkIrq(1'b0);
        wr(A_FL, rnd());
        rd(A_FL, 8'h01 << i);
        wr(A_EN, 32'h01 << i);
        chkIrq(1'b1);
        wr(A_VEC, rnd());
        rd(A_FL, 8'h00);
        chkIrq(1'b0);
      end
    end
    // event beside a clearing write
    i_usb.fire(8'h20);
    fork
      wr(A_VEC, rnd());
      begin
        @(posedge core_clk);
        i_usb.fire(8'h10);
      end
    join
    rd(A_FL, 8'h10);
    wr(A_VEC, 32'h0);
    // new setup inside an open transfer, then after it closed
    wr(A_EN, 32'h01);
    i_usb.pair(8'h04, 8'h02);
    rd(A_FL, 8'h05);
    chkIrq(1'b1);
    wr(A_VEC, 32'h0);
    i_usb.fire(8'h01);
    i_usb.fire(8'h02);
    rd(A_FL, 8'h00);
    // random events under a random clock enable
    repeat (4) begin
      v = rnd();
      @(posedge core_clk);
      clkEn <= v[0];
      i_usb.fire(v[15:8] & 8'hF4);
      clkEn <= 1'b1;
      rd(A_FL, v[15:8] & 8'hF4 & {8{v[0]}});
      wr(A_VEC, 32'h0);
    end
    // =====================================================================
    // pseudo frames while unlocked
    wr(A_EN, 32'h08);
    i_usb.lock(1'b0);
    waitIrq(n);
    check("first", {32'h0, (n >= FC && n <= FC + 2)}, 33'h1);
    t1 = $time;
    wr(A_VEC, 32'h0);
    waitIrq(n);
    check("period", 33'(($time - t1) / 25), 33'(FC));
    // host frame starts keep the pseudo timer from firing
    wr(A_VEC, 32'h0);
    repeat (6) i_usb.fire(8'h10);
    rd(A_FL, 8'h10);
    i_usb.lock(1'b1);
    wr(A_VEC, 32'h0);
    repeat (3 * FC) @(posedge core_clk);
    chkIrq(1'b0);
    tallyAndFinish();
  end
endmodule
